// ### logic/dacso_cfg.svh
// constants of the dual converter clock, sync and output block
// assumes one 100 MHz reference clock and byte-wide register access
`ifndef DACSO_CFG_SVH
`define DACSO_CFG_SVH

`define DACSO_CLK_PERIOD_NS   10
`define DACSO_CLK_MHZ         100
`define DACSO_DCS_MIN_MHZ     40
`define DACSO_DCS_RELOCK_NS   1500
`define DACSO_DCS_RELOCK_CYC  ((`DACSO_DCS_RELOCK_NS + `DACSO_CLK_PERIOD_NS - 1) / `DACSO_CLK_PERIOD_NS)
`define DACSO_DIV_MAX         8
`define DACSO_LATENCY         9
`define DACSO_STBY_WAKE_CYC   8
`define DACSO_WAKE_SHIFT      4

`define DACSO_ADDR_PWR        8'h08
`define DACSO_ADDR_DCS        8'h09
`define DACSO_ADDR_DIV        8'h0B
`define DACSO_ADDR_FMT        8'h14
`define DACSO_ADDR_SYNC       8'h3A
`define DACSO_ADDR_STAT       8'h3B

`define DACSO_SYNC_EN_BIT     1
`define DACSO_DCS_EN_BIT      0
`define DACSO_FMT_TWOS_BIT    0

`define DACSO_RST_PWR         2'h0
`define DACSO_RST_DCS         1'h1
`define DACSO_RST_DIV         3'h0
`define DACSO_RST_FMT         1'h0
`define DACSO_RST_SYNC        8'h00

`endif

// ### logic/dacso_pkg.sv
// types of the dual converter clock, sync and output block
// assumes dacso_cfg.svh is on the include path
package dacso_pkg;

  typedef logic [15:0] dacso_word_t;
  typedef logic signed [17:0] dacso_ana_t;

  typedef enum logic [1:0] {
    DACSO_PWR_RUN  = 2'h0,
    DACSO_PWR_DOWN = 2'h1,
    DACSO_PWR_WAKE = 2'h3,
    DACSO_PWR_STBY = 2'h2
  } dacso_pwr_e;

  typedef enum logic [2:0] {
    DACSO_SER_IDLE   = 3'h0,
    DACSO_SER_A_SET  = 3'h1,
    DACSO_SER_A_RISE = 3'h3,
    DACSO_SER_B_SET  = 3'h2,
    DACSO_SER_B_FALL = 3'h6
  } dacso_ser_e;

  typedef struct packed {
    dacso_word_t a;
    dacso_word_t b;
  } dacso_pair_s;

endpackage : dacso_pkg

// ### logic/dacso_top.sv
// clock divider, sync, stabilizer, power control and ddr output of a dual converter
// assumes synchronous inputs on i_ref_clk and a simple byte register port
//
// Function
// RULE_01 - divide sample clock by one to eight
// RULE_02 - sync enable bit resynchronizes divider
// RULE_03 - valid sync resets divider to start
// RULE_04 - sync input passes through synchronizer
// RULE_05 - controller sends sync aligned to clock
// RULE_06 - stabilizer gives fifty percent internal duty
// RULE_07 - stabilizer inoperative below forty megahertz
// RULE_08 - stabilizer relocks after frequency change
// RULE_09 - sleep pin or register powers down
// RULE_10 - outputs high impedance while powered down
// RULE_11 - wake time grows with down time
// RULE_12 - standby keeps reference, wakes faster; code waits a fixed 8 cycles, longer than after under 112 cycles down
// RULE_13 - register selects offset binary or twos
// RULE_14 - output appears nine sample clocks later
// RULE_15 - channel a valid at clock rise
// RULE_16 - channel b valid at clock fall
// RULE_17 - saturating codes, twos inverts top bit
// RULE_18 - sample taken on sample clock rise
`include "dacso_cfg.svh"

module dacso_top
  import dacso_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic        i_sleep_pin,
  input  wire logic        i_div_align,
  input  wire dacso_ana_t  i_ana_a,
  input  wire dacso_ana_t  i_ana_b,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_conv_clk,
  output logic             o_sample_stb,
  output dacso_word_t      o_sample_a,
  output dacso_word_t      o_sample_b,
  output logic             o_sample_vld,
  output dacso_word_t      o_dout,
  output logic             o_dout_oe,
  output logic             o_fwd_clk,
  output logic             o_fwd_clk_oe,
  output logic             o_dcs_locked,
  output logic             o_powered_down
);

  localparam int unsigned  RELOCK_CYC = `DACSO_DCS_RELOCK_CYC;
  localparam logic [7:0]   RELOCK_W   = 8'(RELOCK_CYC);
  localparam int unsigned  PIPE_DEPTH = `DACSO_LATENCY;
  localparam logic [15:0]  STBY_WAKE  = 16'(`DACSO_STBY_WAKE_CYC);

  // ---------------- functions ----------------
  // clip a signed core value into the 16-bit offset binary range
  function automatic dacso_word_t sat_offset(input dacso_ana_t v);
    dacso_word_t r;
    r = 16'h0000;
    if (v < -18'sd32768) begin
      r = 16'h0000;
    end else if (v > 18'sd32767) begin
      r = 16'hFFFF;
    end else begin
      r = {~v[15], v[14:0]};
    end
    return r;
  endfunction : sat_offset

  // offset binary or twos complement differ only in the top bit
  function automatic dacso_word_t fmt_word(input dacso_ana_t v, input logic twos);
    dacso_word_t r;
    r = sat_offset(v);
    r[15] = r[15] ^ twos;
    return r;
  endfunction : fmt_word

  // stabilizer works only when the divided rate is at least the floor
  function automatic logic dcs_rate_ok(input logic [2:0] ratio_m1);
    logic [7:0] ratio;
    ratio = {5'h00, ratio_m1} + 8'h01;
    return (16'(ratio) * 16'(`DACSO_DCS_MIN_MHZ)) <= 16'(`DACSO_CLK_MHZ);
  endfunction : dcs_rate_ok

  // ---------------- register file ----------------
  logic [1:0]  pwr_mode_r;
  logic        dcs_en_r;
  logic [2:0]  div_ratio_r;
  logic        fmt_twos_r;
  logic [7:0]  sync_ctrl_r;

  wire         wr_pwr    = i_reg_wr && (i_reg_addr == `DACSO_ADDR_PWR);
  wire         wr_dcs    = i_reg_wr && (i_reg_addr == `DACSO_ADDR_DCS);
  wire         wr_div    = i_reg_wr && (i_reg_addr == `DACSO_ADDR_DIV);
  wire         wr_fmt    = i_reg_wr && (i_reg_addr == `DACSO_ADDR_FMT);
  wire         wr_sync   = i_reg_wr && (i_reg_addr == `DACSO_ADDR_SYNC);
  wire         ratio_chg = wr_div && (i_reg_wdata[2:0] != div_ratio_r);

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwr_mode_r  <= `DACSO_RST_PWR;
      dcs_en_r    <= `DACSO_RST_DCS;
      div_ratio_r <= `DACSO_RST_DIV;
      fmt_twos_r  <= `DACSO_RST_FMT;
      sync_ctrl_r <= `DACSO_RST_SYNC;
    end else if (i_ce) begin
      if (wr_pwr) pwr_mode_r <= i_reg_wdata[1:0];
      if (wr_dcs) dcs_en_r <= i_reg_wdata[`DACSO_DCS_EN_BIT];
      // RULE_01 ratio one to eight
      if (wr_div) div_ratio_r <= i_reg_wdata[2:0];
      // RULE_13 output coding select
      if (wr_fmt) fmt_twos_r <= i_reg_wdata[`DACSO_FMT_TWOS_BIT];
      if (wr_sync) sync_ctrl_r <= i_reg_wdata;
    end
  end

  // ---------------- sync input ----------------
  logic sync_meta_r;
  logic sync_s_r;
  logic sync_d_r;

  // RULE_04 two-stage synchronizer
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_meta_r <= 1'b0;
      sync_s_r    <= 1'b0;
      sync_d_r    <= 1'b0;
    end else if (i_ce) begin
      sync_meta_r <= i_div_align;
      sync_s_r    <= sync_meta_r;
      sync_d_r    <= sync_s_r;
    end
  end

  wire sync_en    = sync_ctrl_r[`DACSO_SYNC_EN_BIT];
  // RULE_02 gated by enable bit
  wire sync_pulse = sync_en && sync_s_r && !sync_d_r;

  // ---------------- clock divider ----------------
  logic [2:0] div_cnt_r;
  wire        div_wrap = (div_cnt_r >= div_ratio_r);
  wire        smp_stb  = (div_cnt_r == 3'h0);

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_cnt_r <= 3'h0;
    end else if (i_ce) begin
      // RULE_03 back to initial state
      if (sync_pulse || ratio_chg) begin
        div_cnt_r <= 3'h0;
      end else if (div_wrap) begin
        div_cnt_r <= 3'h0;
      end else begin
        div_cnt_r <= div_cnt_r + 3'h1;
      end
    end
  end

  // ---------------- duty-cycle stabilizer ----------------
  logic [7:0] relock_cnt_r;
  logic       dcs_locked_r;
  wire        dcs_ok     = dcs_en_r && dcs_rate_ok(div_ratio_r);
  wire [3:0]  half_ratio = ({1'b0, div_ratio_r} + 4'h2) >> 1;
  // RULE_06 regenerated falling edge
  wire        conv_dcs   = ({1'b0, div_cnt_r} < half_ratio);
  wire        conv_raw   = smp_stb;
  // RULE_08 bypass until relocked
  wire        conv_nxt   = (dcs_locked_r ? conv_dcs : conv_raw);

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      relock_cnt_r <= 8'h00;
      dcs_locked_r <= 1'b0;
    end else if (i_ce) begin
      // RULE_07 no lock below rate floor
      if (!dcs_ok || ratio_chg || wr_dcs) begin
        relock_cnt_r <= 8'h00;
        dcs_locked_r <= 1'b0;
      // RULE_08 fixed relock wait
      end else if (!dcs_locked_r) begin
        if (relock_cnt_r >= RELOCK_W - 8'h01) begin
          dcs_locked_r <= 1'b1;
        end else begin
          relock_cnt_r <= relock_cnt_r + 8'h01;
        end
      end
    end
  end

  // ---------------- power control ----------------
  dacso_pwr_e  pwr_r;
  dacso_pwr_e  pwr_nxt;
  logic [15:0] down_cnt_r;
  logic [15:0] wake_cnt_r;

  // RULE_09 pin or register request
  wire pd_req   = i_sleep_pin || (pwr_mode_r == 2'h1) || (pwr_mode_r == 2'h3);
  // RULE_12 standby only from register
  wire stby_req = !pd_req && (pwr_mode_r == 2'h2);
  wire running  = (pwr_r == DACSO_PWR_RUN);
  wire wake_done = (wake_cnt_r <= 16'h0001);
  // RULE_11 wake scales with time down
  wire [15:0] wake_load = (down_cnt_r >> `DACSO_WAKE_SHIFT) + 16'h0001;

  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      DACSO_PWR_RUN: begin
        if (pd_req) pwr_nxt = DACSO_PWR_DOWN;
        else if (stby_req) pwr_nxt = DACSO_PWR_STBY;
      end
      DACSO_PWR_DOWN: begin
        if (!pd_req) pwr_nxt = DACSO_PWR_WAKE;
      end
      DACSO_PWR_STBY: begin
        if (pd_req) pwr_nxt = DACSO_PWR_DOWN;
        else if (!stby_req) pwr_nxt = DACSO_PWR_WAKE;
      end
      DACSO_PWR_WAKE: begin
        if (pd_req) pwr_nxt = DACSO_PWR_DOWN;
        else if (stby_req) pwr_nxt = DACSO_PWR_STBY;
        else if (wake_done) pwr_nxt = DACSO_PWR_RUN;
      end
      default: pwr_nxt = DACSO_PWR_DOWN;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwr_r      <= DACSO_PWR_RUN;
      down_cnt_r <= 16'h0000;
      wake_cnt_r <= 16'h0000;
    end else if (i_ce) begin
      pwr_r <= pwr_nxt;
      if (pwr_r == DACSO_PWR_DOWN) begin
        if (down_cnt_r != 16'hFFFF) down_cnt_r <= down_cnt_r + 16'h0001;
      end else if (pwr_r == DACSO_PWR_RUN) begin
        down_cnt_r <= 16'h0000;
      end
      // RULE_11 load wake delay on leaving down
      if (pwr_r == DACSO_PWR_DOWN && pwr_nxt == DACSO_PWR_WAKE) begin
        wake_cnt_r <= wake_load;
      // RULE_12 short fixed wake from standby
      end else if (pwr_r == DACSO_PWR_STBY && pwr_nxt == DACSO_PWR_WAKE) begin
        wake_cnt_r <= STBY_WAKE;
      end else if (pwr_r == DACSO_PWR_WAKE && !wake_done) begin
        wake_cnt_r <= wake_cnt_r - 16'h0001;
      end
    end
  end

  // ---------------- sampling and latency pipeline ----------------
  dacso_pair_s pipe_r [PIPE_DEPTH];
  logic [PIPE_DEPTH-1:0] pipe_v_r;
  // RULE_17 saturate and code both channels
  wire dacso_pair_s smp_pair = '{a: fmt_word(i_ana_a, fmt_twos_r),
                                 b: fmt_word(i_ana_b, fmt_twos_r)};
  // RULE_18 capture on sample clock rise
  wire         smp_take = smp_stb && running;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pipe_r[0]   <= '0;
      pipe_v_r[0] <= 1'b0;
    end else if (i_ce) begin
      if (!running) begin
        pipe_v_r[0] <= 1'b0;
      end else if (smp_take) begin
        pipe_r[0]   <= smp_pair;
        pipe_v_r[0] <= 1'b1;
      end
    end
  end

  // RULE_14 one stage per sample clock
  genvar gi;
  generate
    for (gi = 1; gi < PIPE_DEPTH; gi++) begin : g_pipe
      always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          pipe_r[gi]   <= '0;
          pipe_v_r[gi] <= 1'b0;
        end else if (i_ce) begin
          if (!running) begin
            pipe_v_r[gi] <= 1'b0;
          end else if (smp_take) begin
            pipe_r[gi]   <= pipe_r[gi-1];
            pipe_v_r[gi] <= pipe_v_r[gi-1];
          end
        end
      end
    end
  endgenerate

  dacso_pair_s out_pair_r;
  logic        out_vld_r;
  logic        conv_clk_r;
  logic        stb_r;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_pair_r <= '0;
      out_vld_r  <= 1'b0;
      conv_clk_r <= 1'b0;
      stb_r      <= 1'b0;
    end else if (i_ce) begin
      conv_clk_r <= running && conv_nxt;
      stb_r      <= smp_take;
      // RULE_14 ninth sample clock presents word
      out_vld_r  <= smp_take && pipe_v_r[PIPE_DEPTH-1];
      if (smp_take && pipe_v_r[PIPE_DEPTH-1]) begin
        out_pair_r <= pipe_r[PIPE_DEPTH-1];
      end
    end
  end

  // ---------------- ddr serializer ----------------
  dacso_ser_e  ser_r;
  dacso_ser_e  ser_nxt;
  dacso_pair_s pend_r;
  logic        pend_v_r;
  dacso_pair_s cur_r;
  dacso_word_t dout_r;
  logic        fwd_r;

  always_comb begin
    ser_nxt = ser_r;
    case (ser_r)
      DACSO_SER_IDLE:   if (pend_v_r) ser_nxt = DACSO_SER_A_SET;
      DACSO_SER_A_SET:  ser_nxt = DACSO_SER_A_RISE;
      DACSO_SER_A_RISE: ser_nxt = DACSO_SER_B_SET;
      DACSO_SER_B_SET:  ser_nxt = DACSO_SER_B_FALL;
      DACSO_SER_B_FALL: ser_nxt = pend_v_r ? DACSO_SER_A_SET : DACSO_SER_IDLE;
      default:          ser_nxt = DACSO_SER_IDLE;
    endcase
  end

  wire ser_load = (ser_nxt == DACSO_SER_A_SET);

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ser_r    <= DACSO_SER_IDLE;
      pend_r   <= '0;
      pend_v_r <= 1'b0;
      cur_r    <= '0;
      dout_r   <= 16'h0000;
      fwd_r    <= 1'b0;
    end else if (i_ce) begin
      if (!running) begin
        ser_r    <= DACSO_SER_IDLE;
        pend_v_r <= 1'b0;
        fwd_r    <= 1'b0;
      end else begin
        ser_r <= ser_nxt;
        // newest pair wins when words arrive faster than four cycles
        if (out_vld_r) begin
          pend_r   <= out_pair_r;
          pend_v_r <= 1'b1;
        end else if (ser_load) begin
          pend_v_r <= 1'b0;
        end
        if (ser_load) cur_r <= pend_r;
        case (ser_nxt)
          // RULE_15 a settles before rise
          DACSO_SER_A_SET:  dout_r <= pend_r.a;
          DACSO_SER_A_RISE: fwd_r <= 1'b1;
          // RULE_16 b settles before fall
          DACSO_SER_B_SET:  dout_r <= cur_r.b;
          DACSO_SER_B_FALL: fwd_r <= 1'b0;
          default:          fwd_r <= 1'b0;
        endcase
      end
    end
  end

  // ---------------- register read ----------------
  wire [7:0] stat_word = {4'h0, dcs_ok, running, pwr_r != DACSO_PWR_RUN, dcs_locked_r};
  logic [7:0] rd_mux;

  always_comb begin
    case (i_reg_addr)
      `DACSO_ADDR_PWR:  rd_mux = {6'h00, pwr_mode_r};
      `DACSO_ADDR_DCS:  rd_mux = {7'h00, dcs_en_r};
      `DACSO_ADDR_DIV:  rd_mux = {5'h00, div_ratio_r};
      `DACSO_ADDR_FMT:  rd_mux = {7'h00, fmt_twos_r};
      `DACSO_ADDR_SYNC: rd_mux = sync_ctrl_r;
      `DACSO_ADDR_STAT: rd_mux = stat_word;
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata <= 8'h00;
    end else if (i_ce && i_reg_rd) begin
      o_reg_rdata <= rd_mux;
    end
  end

  // ---------------- outputs ----------------
  assign o_conv_clk     = conv_clk_r;
  assign o_sample_stb   = stb_r;
  assign o_sample_a     = out_pair_r.a;
  assign o_sample_b     = out_pair_r.b;
  assign o_sample_vld   = out_vld_r;
  assign o_dout         = dout_r;
  // RULE_10 drivers released while down
  assign o_dout_oe      = running;
  assign o_fwd_clk      = fwd_r;
  assign o_fwd_clk_oe   = running;
  assign o_dcs_locked   = dcs_locked_r;
  assign o_powered_down = !running;

endmodule : dacso_top

// ### test/dacso_properties.sv
// assertions on the divider, stabilizer, power and ddr lane ports
// assumes binding to dacso_top, whose only clock is i_ref_clk
`include "dacso_cfg.svh"

module dacso_properties
  import dacso_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rstn,
  input wire logic        i_ce,
  input wire logic        i_sleep_pin,
  input wire logic        i_div_align,
  input wire logic        i_reg_wr,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        o_sample_stb,
  input wire dacso_word_t o_dout,
  input wire logic        o_dout_oe,
  input wire logic        o_fwd_clk,
  input wire logic        o_fwd_clk_oe,
  input wire logic        o_dcs_locked,
  input wire logic        o_powered_down
);
  logic [2:0] div_r;
  logic       sync_en_r;
  logic [8:0] unl_r;
  wire        wr_w = i_ce && i_reg_wr;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_r     <= 3'h0;
      sync_en_r <= 1'b0;
    end else if (wr_w && i_reg_addr == `DACSO_ADDR_DIV) begin
      div_r <= i_reg_wdata[2:0];
    end else if (wr_w && i_reg_addr == `DACSO_ADDR_SYNC) begin
      sync_en_r <= i_reg_wdata[`DACSO_SYNC_EN_BIT];
    end
  end

  // cycles spent unlocked since reset or the last lock
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) unl_r <= 9'h000;
    else if (o_dcs_locked) unl_r <= 9'h000;
    else if (unl_r != 9'h1FF) unl_r <= unl_r + 9'h001;
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  a_down_drivers_off: assert property (o_powered_down |-> !o_dout_oe && !o_fwd_clk_oe)
    else $error("lane driven while powered down");
  a_sleep_powers_down: assert property (i_sleep_pin && i_ce |-> ##[1:2] o_powered_down)
    else $error("sleep pin did not power down");
  a_rise_holds_a: assert property ($rose(o_fwd_clk) |-> $stable(o_dout))
    else $error("data moved at forwarded clock rise");
  a_fall_holds_b: assert property ($fell(o_fwd_clk) && o_fwd_clk_oe |-> $stable(o_dout))
    else $error("data moved at forwarded clock fall");
  a_fwd_high_two: assert property ($rose(o_fwd_clk) |=>
    (o_fwd_clk || o_powered_down) ##1 (!o_fwd_clk || o_powered_down))
    else $error("forwarded clock high time wrong");
  a_sync_realigns: assert property (sync_en_r && $rose(i_div_align) && !o_powered_down
    |-> ##[4:6] o_sample_stb)
    else $error("sync pulse did not restart divider");
  a_lock_after_wait: assert property ($rose(o_dcs_locked) |-> unl_r >= 9'h095)
    else $error("stabilizer locked too early");
  a_slow_never_locks: assert property (div_r > 3'h1 && $past(div_r) > 3'h1
    |-> !o_dcs_locked)
    else $error("stabilizer locked on slow clock");
endmodule : dacso_properties

bind dacso_top dacso_properties chk_u (
  .i_ref_clk, .i_rstn, .i_ce, .i_sleep_pin, .i_div_align, .i_reg_wr, .i_reg_addr,
  .i_reg_wdata, .o_sample_stb, .o_dout, .o_dout_oe, .o_fwd_clk, .o_fwd_clk_oe,
  .o_dcs_locked, .o_powered_down
);

// ### test/dacso_capture.sv
// capture logic on the far side of the ddr lane
// assumes data and forwarded clock change on reference edges
module dacso_capture
  import dacso_pkg::*;
(
  input  wire dacso_word_t i_dout,
  input  wire logic        i_dout_oe,
  input  wire logic        i_fwd_clk,
  input  wire logic        i_fwd_clk_oe,
  output dacso_pair_s      o_pair,
  output int               o_count
);
  timeunit 1ns;
  timeprecision 1ps;
  dacso_word_t held_r, a_r;
  // a released lane shows the inverse of its last driven value
  always_latch if (i_dout_oe) held_r <= i_dout;
  wire dacso_word_t line_w = i_dout_oe ? i_dout : ~held_r;
  // a released clock reads low at the receiver
  wire logic        clk_w  = i_fwd_clk_oe && i_fwd_clk;
  initial o_count = 0;
  always @(posedge clk_w) a_r <= line_w;
  always @(negedge clk_w) begin
    o_pair  <= '{a: a_r, b: line_w};
    o_count <= o_count + 1;
  end
endmodule : dacso_capture

// ### test/test_dual_adc_clock_sync_output.sv
// self-checking bench of the clock, sync, power and ddr output block
// assumes the checker is bound and the capture model sits on the lane
`include "dacso_cfg.svh"

module test_dual_adc_clock_sync_output
  import dacso_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, ce, sleep, align, wr, rd, conv, stb, vld;
  logic        dout_oe, fwd, fwd_oe, locked, down;
  logic [7:0]  addr, wdata, rdata, d;
  dacso_ana_t  ana_a, ana_b;
  dacso_word_t sa, sb, dout;
  dacso_pair_s cap, em, el, exp_q[$], lane_q[$];
  int          cap_n, bad_count, checks, cyc, n = 1, k, hi, seed = 9;
  int          stamp_q[$], lane_t[$], wk[2];
  bit          twos, ce_q, skip = 1'b1;
  logic [7:0]  ra[5] = '{8'h08, 8'h09, 8'h0B, 8'h14, 8'h3A};
  logic [7:0]  rv[5] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  bit          se[2] = '{1'b1, 1'b0};
  int          dn[2] = '{40, 808};

  dacso_top dut_u (
    .i_ref_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_sleep_pin(sleep), .i_div_align(align),
    .i_ana_a(ana_a), .i_ana_b(ana_b), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_conv_clk(conv), .o_sample_stb(stb),
    .o_sample_a(sa), .o_sample_b(sb), .o_sample_vld(vld), .o_dout(dout),
    .o_dout_oe(dout_oe), .o_fwd_clk(fwd), .o_fwd_clk_oe(fwd_oe), .o_dcs_locked(locked),
    .o_powered_down(down)
  );
  dacso_capture cap_u (
    .i_dout(dout), .i_dout_oe(dout_oe), .i_fwd_clk(fwd), .i_fwd_clk_oe(fwd_oe),
    .o_pair(cap), .o_count(cap_n)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  function automatic dacso_word_t fmt(input dacso_ana_t v);
    dacso_ana_t s;
    s = v > 18'sh07FFF ? 18'sh07FFF : (v < 18'sh38000 ? 18'sh38000 : v);
    return twos ? s[15:0] : {~s[15], s[14:0]};
  endfunction : fmt

  task automatic wreg(input logic [7:0] a, dat);
    @(negedge clk);
    {wr, addr, wdata} = {1'b1, a, dat};
    @(negedge clk);
    wr = 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [7:0] dat);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
    dat = rdata;
  endtask : rreg

  // new ratio and coding, in-flight samples dropped meanwhile
  task automatic settle(input int r, input bit t);
    skip = 1'b1;
    wreg(`DACSO_ADDR_DIV, 8'(r - 1));
    wreg(`DACSO_ADDR_FMT, {7'h00, t});
    n = r;
    twos = t;
    repeat (90) @(negedge clk);
    skip = 1'b0;
  endtask : settle

  task automatic gap(output int g);
    g = 0;
    while (stb !== 1'b1) @(negedge clk);
    @(negedge clk);
    while (stb !== 1'b1 && g < 20) begin
      g++;
      @(negedge clk);
    end
    g++;
  endtask : gap

  task automatic duty(output int h);
    h = 0;
    repeat (16) begin
      @(negedge clk);
      h += int'(conv === 1'b1);
    end
  endtask : duty

  always @(posedge clk) begin
    cyc++;
    ce_q <= ce;
    if (cyc == 10000) begin
      bad_count++;
      conclude();
    end
  end

  // note each sample taken on the rise just passed
  always @(negedge clk) begin
    if (stb === 1'b1 && ce_q) begin
      exp_q.push_back('{a: fmt(ana_a), b: fmt(ana_b)});
      stamp_q.push_back(cyc);
    end
    ana_a = dacso_ana_t'($random(seed) % 40000);
    ana_b = dacso_ana_t'($random(seed) % 40000);
  end

  always @(negedge clk) begin
    if (vld === 1'b1 && ce_q && exp_q.size() != 0) begin
      em = exp_q.pop_front();
      lane_q.push_back(em);
      lane_t.push_back(cyc);
      if (!skip) begin
        chk("latency", 9 * n, cyc - stamp_q.pop_front());
        chk("sample_pair", em, {sa, sb});
      end else void'(stamp_q.pop_front());
    end else if (vld === 1'b1 && ce_q && !skip) chk("spare_sample", 0, 1);
  end

  // a pair reaches the far side on the fall five cycles after its valid
  always @(cap_n) begin
    while (lane_q.size() != 0 && lane_t[0] + 5 < cyc) begin
      el = lane_q.pop_front();
      void'(lane_t.pop_front());
      if (!skip && n >= 4) chk("lane_drop", 0, 1);
    end
    if (lane_q.size() != 0 && lane_t[0] + 5 == cyc) begin
      el = lane_q.pop_front();
      void'(lane_t.pop_front());
      if (!skip && n >= 4) chk("lane_pair", el, cap);
    end else if (!skip && n >= 4) chk("spare_lane", 0, 1);
  end

  initial begin
    {rstn, sleep, align, wr, rd, addr, wdata, ana_a, ana_b} = '0;
    ce = 1'b1;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    foreach (ra[i]) begin
      rreg(ra[i], d);
      chk("reg_reset", rv[i], d);
    end
    wreg(8'h3A, 8'hFF);
    rreg(8'h3A, d);
    chk("sync_reg", 8'hFF, d);
    wreg(8'h3A, 8'h00);
    ce = 1'b0;
    wreg(8'h3A, 8'h5A);
    ce = 1'b1;
    rreg(8'h3A, d);
    chk("ce_freeze", 8'h00, d);
    wreg(8'h55, 8'hA5);
    rreg(8'h55, d);
    chk("unmapped", 8'h00, d);
    repeat (150) @(negedge clk);
    chk("lock_after_reset", 1, locked);
    $display("test registers done");
    for (int r = 1; r <= 8; r++) begin
      settle(r, r[0]);
      gap(k);
      chk("strobe_gap", r, k);
      repeat (120) @(negedge clk);
      $display("test ratio %0d done", r);
    end
    skip = 1'b1;
    duty(hi);
    chk("duty_bypass", 2, hi);
    chk("slow_unlocked", 0, locked);
    wreg(`DACSO_ADDR_DIV, 8'h01);
    n = 2;
    k = 0;
    while (locked !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    chk("relock_wait", 1, k >= 148 && k <= 151);
    duty(hi);
    chk("duty_locked", 8, hi);
    $display("test stabilizer done");
    wreg(`DACSO_ADDR_DIV, 8'h07);
    repeat (10) @(negedge clk);
    foreach (se[i]) begin
      wreg(`DACSO_ADDR_SYNC, {6'h00, se[i], 1'b0});
      while (stb !== 1'b1) @(negedge clk);
      // pulse launched on the sample clock
      align = 1'b1;
      k = 0;
      do begin
        @(negedge clk);
        align = 1'b0;
        k++;
      end while (stb !== 1'b1 && k < 12);
      chk("sync_delay", se[i] ? 4 : 8, k);
    end
    $display("test sync done");
    foreach (dn[i]) begin
      sleep = 1'b1;
      repeat (dn[i]) @(negedge clk);
      chk("pin_down", 3'b100, {down, dout_oe, fwd_oe});
      sleep = 1'b0;
      wk[i] = 0;
      while (down !== 1'b0 && wk[i] < 200) begin
        @(negedge clk);
        wk[i]++;
      end
    end
    chk("wake_growth", 48, wk[1] - wk[0]);
    wreg(`DACSO_ADDR_PWR, 8'h01);
    repeat (20) @(negedge clk);
    chk("reg_down", 3'b100, {down, dout_oe, fwd_oe});
    wreg(`DACSO_ADDR_PWR, 8'h02);
    repeat (20) @(negedge clk);
    rreg(`DACSO_ADDR_STAT, d);
    chk("stby_status", 1, d[1]);
    exp_q.delete();
    stamp_q.delete();
    lane_q.delete();
    lane_t.delete();
    wreg(`DACSO_ADDR_PWR, 8'h00);
    k = 0;
    while (down !== 1'b0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk("stby_wake", 1, k >= 7 && k <= 9);
    $display("test power done");
    settle(4, 1'b1);
    repeat (120) @(negedge clk);
    $display("test resume done");
    conclude();
  end
endmodule : test_dual_adc_clock_sync_output
